//--- mtp_defs.svh
/*
  Constants of the motor thermal protection block: register offsets,
  field positions, reset values, thermal levels and timing figures.
  Assumes it is included by bare name from the package and the modules.
*/
`ifndef MTP_DEFS_SVH
`define MTP_DEFS_SVH

// ======================================================================
// Timing
`define MTP_CLK_HZ 32'h017D7840
`define MTP_TICK_MS 32'h00000001
`define MTP_TICK_CYC ((`MTP_CLK_HZ / 32'h000003E8) * `MTP_TICK_MS)
`define MTP_PHASE_MS 32'h000001F4

// ======================================================================
// Thermal model scaling
`define MTP_ST_W 40
`define MTP_ISQ_W 16
`define MTP_FRAC 28
`define MTP_ALARM_LVL (40'h000000006E << `MTP_FRAC)
`define MTP_TRIP_LVL (40'h000000007D << `MTP_FRAC)
`define MTP_ISQ_NOM 16'h0100
`define MTP_ISQ_EXC 40'h0000000B40
`define MTP_COLD10_MS 40'h0000007D00
`define MTP_COLD20_MS 40'h000000F618
`define MTP_COLD30_MS 40'h0000017318
`define MTP_GAIN(ms) (`MTP_TRIP_LVL / ((ms) * `MTP_ISQ_EXC))

// ======================================================================
// PTC probe loop, ohms
`define MTP_PTC_MIN 12'hA8C
`define MTP_PTC_MAX 12'hC1C
`define MTP_PTC_RST 12'hB54

// ======================================================================
// Register word offsets (byte address bits 4:2)
`define MTP_REG_CTRL 3'h0
`define MTP_REG_STAT 3'h1
`define MTP_REG_THERM 3'h2
`define MTP_REG_IRQ_STAT 3'h3
`define MTP_REG_IRQ_MASK 3'h4
`define MTP_REG_PTC_THR 3'h5
`define MTP_REG_CLEAR 3'h6

// ======================================================================
// Control fields
`define MTP_CTRL_CLASS 1:0
`define MTP_CTRL_TH_DIS 2
`define MTP_CTRL_PTC_EN 3
`define MTP_CTRL_RELAY 4
`define MTP_CTRL_W 5
`define MTP_CTRL_RST 5'h10

// Event bits, shared by status and interrupt registers
`define MTP_EV_ALARM 0
`define MTP_EV_THERM 1
`define MTP_EV_PTC 2
`define MTP_EV_PHASE 3
`define MTP_EV_W 4

`endif

//--- mtp_motor_model.sv
/*
  Far-side model: motor current square, PTC probe loop and the line
  isolation contactor feeding the three line-presence pins.
  Assumes the bench drives run, load level, probe ohms and contactor.
*/
`timescale 1ns/10ps

module mtp_motor_model (
  // Clock
  input wire logic mclk_in,
  // Bench controls, and the stop from the protection block
  input wire logic run_in,
  input wire logic stop_in,
  input wire logic overload_in,
  input wire logic contactor_in,
  input wire logic [11:0] ohms_set_in,
  // Toward the protection block
  output logic [15:0] current_sq_out,
  output logic [11:0] ptc_ohms_out,
  output logic [2:0] line_ok_out
);
  // ======================================================================
  // Motor and probe
  initial begin
    current_sq_out = 16'h0000;
    ptc_ohms_out = 12'h2EE;
    line_ok_out = 3'h0;
  end

  // A stopped motor draws no current
  always @(posedge mclk_in) begin
    ptc_ohms_out <= ohms_set_in;
    line_ok_out <= contactor_in ? 3'h7 : 3'h0;
    if (!run_in || stop_in) begin
      current_sq_out <= 16'h0000;
    end else if (overload_in) begin
      current_sq_out <= 16'h0C40;
    end else begin
      current_sq_out <= 16'h0100;
    end
  end
endmodule : mtp_motor_model

//--- mtp_pkg.sv
/*
  Types of the motor thermal protection block.
  Assumes mtp_defs.svh is on the include path.
*/
`include "mtp_defs.svh"

package mtp_pkg;

  // ======================================================================
  // Protection class select
  typedef enum logic [1:0] {
    MTP_CLASS10,
    MTP_CLASS20,
    MTP_CLASS30
  } mtp_class_type;

  // ======================================================================
  // Control register image
  typedef struct packed {
    logic relay_assign;
    logic ptc_enable;
    logic thermal_disable;
    logic [1:0] protection_class_select;
  } mtp_ctrl_type;

  // Fault and alarm set
  typedef struct packed {
    logic phase_fail;
    logic ptc_trip;
    logic thermal_overload_fault;
    logic overload_alarm;
  } mtp_events_type;

endpackage : mtp_pkg

//--- mtp_protect.sv
/*
  Motor thermal protection top: class-timed thermal model, overload
  alarm and trip, PTC probe trip, phase-failure trip, retained state
  save and restore, Avalon-MM registers and one interrupt.
  Assumes current square and PTC ohms come from logic on mclk_in; the
  run, line and power inputs are pins and are synchronised here.
*/
// The register addresses and the Avalon-MM register port were chosen for this implementation.
// Behaviour
// - Class 10 applies after reset
// - Register field selects class 10, 20, 30
// - Alarm while thermal state above 110 percent
// - Above 125 percent: fault and stop motor
// - No thermal update while control power absent
// - Save state on stop/power-off, restore on start
// - Relay shows trip unless disabled, if assigned
// - Cold trip at 3.5 In: 32/63/95 s
// - Warm trip at 3.5 In: 16/32/48 s
// - PTC and thermal model trip independently
// - PTC trips at 2700..3100 ohm threshold
// - Phase failure if lines absent 500 ms after run
`timescale 1ns/10ps
`include "mtp_defs.svh"

module mtp_protect #(
  parameter int TICK_CYC = `MTP_TICK_CYC,
  parameter int PHASE_MS = `MTP_PHASE_MS
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Sensing
  input wire logic [`MTP_ISQ_W-1:0] current_sq_in,
  input wire logic [11:0] ptc_ohms_in,
  input wire logic run_cmd_in,
  input wire logic [2:0] line_ok_in,
  input wire logic power_ok_in,
  // Retained memory
  input wire logic [`MTP_ST_W-1:0] retained_data_in,
  output logic [`MTP_ST_W-1:0] retained_data_out,
  output logic retained_write_out,
  // Outputs
  output logic motor_stop_out,
  output logic thermal_relay_out,
  output logic irq_out
);

  // ======================================================================
  // Pin synchronisers
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic run_q;
  logic power_q;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {power_ok_in, line_ok_in, run_cmd_in};
      sync_b <= sync_a;
    end
  end

  wire logic run_s = sync_b[0];
  wire logic lines_ok = &sync_b[3:1];
  wire logic power_s = sync_b[4];
  wire logic run_rise = run_s & ~run_q;
  wire logic run_fall = ~run_s & run_q;
  wire logic power_rise = power_s & ~power_q;
  wire logic power_fall = ~power_s & power_q;

  // ======================================================================
  // Millisecond tick
  logic [31:0] tick_cnt;
  wire logic tick = tick_cnt == 32'(TICK_CYC - 1);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick ? '0 : tick_cnt + 32'h1;
    end
  end

  // ======================================================================
  // Registers
  mtp_pkg::mtp_ctrl_type ctrl;
  mtp_pkg::mtp_events_type ev_live;
  logic [`MTP_EV_W-1:0] irq_stat;
  logic [`MTP_EV_W-1:0] irq_mask;
  logic [11:0] ptc_thr;
  logic served;

  wire logic req = avs_read_in | avs_write_in;
  wire logic wr_go = avs_write_in & served;
  wire logic [2:0] word = avs_address_in[4:2];
  wire logic wr_ctrl = wr_go && word == `MTP_REG_CTRL;
  wire logic wr_stat = wr_go && word == `MTP_REG_IRQ_STAT;
  wire logic wr_mask = wr_go && word == `MTP_REG_IRQ_MASK;
  wire logic wr_thr = wr_go && word == `MTP_REG_PTC_THR;
  wire logic wr_clr = wr_go && word == `MTP_REG_CLEAR;
  wire logic [11:0] thr_in = avs_writedata_in[11:0];
  wire logic [11:0] thr_clamped = thr_in < `MTP_PTC_MIN ? `MTP_PTC_MIN :
                                  thr_in > `MTP_PTC_MAX ? `MTP_PTC_MAX : thr_in;

  // One wait state per access; a write takes effect on the edge where
  // waitrequest is low, read data is registered on the edge before it.
  assign avs_waitrequest_out = req & ~served;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      served <= 1'b0;
      ctrl <= `MTP_CTRL_RST;
      irq_mask <= '0;
      ptc_thr <= `MTP_PTC_RST;
    end else begin
      served <= req & ~served;
      if (wr_ctrl) begin
        ctrl <= avs_writedata_in[`MTP_CTRL_W-1:0];
      end
      if (wr_mask) begin
        irq_mask <= avs_writedata_in[`MTP_EV_W-1:0];
      end
      if (wr_thr) begin
        ptc_thr <= thr_clamped;
      end
    end
  end

  // ======================================================================
  // Thermal model
  logic [`MTP_ST_W-1:0] state;
  logic [`MTP_ST_W-1:0] gain;

  always_comb begin
    unique case (ctrl.protection_class_select)
      mtp_pkg::MTP_CLASS20: gain = `MTP_GAIN(`MTP_COLD20_MS);
      mtp_pkg::MTP_CLASS30: gain = `MTP_GAIN(`MTP_COLD30_MS);
      default: gain = `MTP_GAIN(`MTP_COLD10_MS);
    endcase
  end

  wire logic restore = run_rise | power_rise;

  mtp_thermal_acc u_acc (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .tick_in(tick),
    .freeze_in(~power_s),
    .load_in(restore),
    .load_value_in(retained_data_in),
    .gain_in(gain),
    .isq_in(current_sq_in),
    .state_out(state)
  );

  // ======================================================================
  // Alarms and trips
  logic therm_trip;
  logic ptc_trip;
  logic phase_trip;
  logic [9:0] phase_cnt;
  logic phase_wait;

  wire logic over_alarm = state > `MTP_ALARM_LVL;
  wire logic over_trip = state > `MTP_TRIP_LVL & ~ctrl.thermal_disable;
  wire logic ptc_hit = ctrl.ptc_enable & (ptc_ohms_in >= ptc_thr);
  wire logic phase_hit = phase_wait & ~lines_ok & tick &&
                         phase_cnt == 10'(PHASE_MS - 1);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      run_q <= 1'b0;
      power_q <= 1'b0;
      phase_wait <= 1'b0;
      phase_cnt <= '0;
    end else begin
      run_q <= run_s;
      power_q <= power_s;
      if (run_rise) begin
        phase_wait <= 1'b1;
        phase_cnt <= '0;
      end else if (!run_s || lines_ok || phase_hit) begin
        phase_wait <= 1'b0;
      end else if (tick) begin
        phase_cnt <= phase_cnt + 10'h1;
      end
    end
  end

  // Trips latch until software clears them; a trip present at the clear wins
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      therm_trip <= 1'b0;
      ptc_trip <= 1'b0;
      phase_trip <= 1'b0;
    end else begin
      therm_trip <= over_trip | (therm_trip & ~wr_clr);
      ptc_trip <= ptc_hit | (ptc_trip & ~wr_clr);
      phase_trip <= phase_hit | (phase_trip & ~wr_clr);
    end
  end

  assign ev_live = '{phase_fail: phase_trip, ptc_trip: ptc_trip,
                     thermal_overload_fault: therm_trip, overload_alarm: over_alarm};
  assign motor_stop_out = therm_trip | ptc_trip | phase_trip;
  assign thermal_relay_out = therm_trip & ctrl.relay_assign & ~ctrl.thermal_disable;

  // ======================================================================
  // Retained save
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      retained_data_out <= '0;
      retained_write_out <= 1'b0;
    end else begin
      retained_write_out <= run_fall | power_fall;
      if (run_fall || power_fall) begin
        retained_data_out <= state;
      end
    end
  end

  // ======================================================================
  // Interrupts: rising event sets, write one clears, set wins
  logic [`MTP_EV_W-1:0] ev_q;
  wire logic [`MTP_EV_W-1:0] ev_rise = ev_live & ~ev_q;
  wire logic [`MTP_EV_W-1:0] w1c = wr_stat ? avs_writedata_in[`MTP_EV_W-1:0] : '0;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ev_q <= '0;
      irq_stat <= '0;
    end else begin
      ev_q <= ev_live;
      irq_stat <= ev_rise | (irq_stat & ~w1c);
    end
  end

  assign irq_out = |(irq_stat & irq_mask);

  // ======================================================================
  // Read data
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    unique case (word)
      `MTP_REG_CTRL: rd_mux[`MTP_CTRL_W-1:0] = ctrl;
      `MTP_REG_STAT: rd_mux[`MTP_EV_W:0] = {run_s, ev_live};
      `MTP_REG_THERM: rd_mux = state[`MTP_FRAC+7:`MTP_FRAC-24];
      `MTP_REG_IRQ_STAT: rd_mux[`MTP_EV_W-1:0] = irq_stat;
      `MTP_REG_IRQ_MASK: rd_mux[`MTP_EV_W-1:0] = irq_mask;
      `MTP_REG_PTC_THR: rd_mux[11:0] = ptc_thr;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_readdata_out <= '0;
    end else if (avs_read_in && !served) begin
      avs_readdata_out <= rd_mux;
    end
  end

  // ======================================================================
  // Checks
  alarm_level_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state > `MTP_ALARM_LVL) |-> ev_live.overload_alarm)
    else $error("alarm missing above level");
  trip_stops_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state > `MTP_TRIP_LVL && !ctrl.thermal_disable) |=> (therm_trip && motor_stop_out))
    else $error("thermal trip did not stop motor");
  class_reset_a: assert property (@(posedge mclk_in) $fell(rst_in) |->
    ctrl.protection_class_select == mtp_pkg::MTP_CLASS10)
    else $error("class not default after reset");
  class_write_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    wr_ctrl |=> ctrl.protection_class_select == $past(avs_writedata_in[1:0]))
    else $error("class write lost");
  freeze_off_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!power_s && !restore) |=> $stable(state))
    else $error("state moved without power");
  save_stop_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    run_fall |=> (retained_write_out && retained_data_out == $past(state)))
    else $error("state not saved at stop");
  restore_start_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    run_rise |=> state == $past(retained_data_in))
    else $error("state not restored at start");
  relay_gate_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    thermal_relay_out |-> (therm_trip && ctrl.relay_assign && !ctrl.thermal_disable))
    else $error("relay without enabled trip");
  ptc_trip_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (ctrl.ptc_enable && ptc_ohms_in >= ptc_thr) |=> (ptc_trip && motor_stop_out))
    else $error("ptc trip missing");
  ptc_range_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    ptc_thr >= `MTP_PTC_MIN && ptc_thr <= `MTP_PTC_MAX)
    else $error("ptc threshold out of range");
  phase_trip_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(phase_trip) |-> ($past(phase_wait) && !$past(lines_ok)))
    else $error("phase trip without wait");
  wait_ack_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(req) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("bus answer not after one wait");

  trip_seen_c: cover property (@(posedge mclk_in) disable iff (rst_in) $rose(therm_trip));
  ptc_seen_c: cover property (@(posedge mclk_in) disable iff (rst_in) $rose(ptc_trip));
  phase_seen_c: cover property (@(posedge mclk_in) disable iff (rst_in) $rose(phase_trip));
  irq_seen_c: cover property (@(posedge mclk_in) disable iff (rst_in) $rose(irq_out));

endmodule : mtp_protect

//--- mtp_thermal_acc.sv
/*
  Motor thermal state integrator: heats by the excess of squared
  current over nominal, cools by the shortfall, once per tick.
  Assumes tick, load and current square come from the same clock.
*/
`timescale 1ns/10ps
`include "mtp_defs.svh"

module mtp_thermal_acc #(
  parameter int ST_W = `MTP_ST_W,
  parameter int ISQ_W = `MTP_ISQ_W
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Control
  input wire logic tick_in,
  input wire logic freeze_in,
  input wire logic load_in,
  input wire logic [ST_W-1:0] load_value_in,
  input wire logic [ST_W-1:0] gain_in,
  input wire logic [ISQ_W-1:0] isq_in,
  // State
  output logic [ST_W-1:0] state_out
);

  // ======================================================================
  // Step size
  wire logic heat;
  wire logic [ISQ_W-1:0] delta_isq;
  wire logic [ST_W-1:0] step;
  wire logic [ST_W:0] sum_up;
  wire logic [ST_W-1:0] next_state;

  assign heat = isq_in >= `MTP_ISQ_NOM;
  assign delta_isq = heat ? isq_in - `MTP_ISQ_NOM : `MTP_ISQ_NOM - isq_in;
  assign step = ST_W'(gain_in * ST_W'(delta_isq));
  assign sum_up = {1'b0, state_out} + {1'b0, step};
  // Saturate at both ends so a long overload or long rest cannot wrap
  assign next_state = heat ? (sum_up[ST_W] ? {ST_W{1'b1}} : sum_up[ST_W-1:0])
                           : (state_out > step ? state_out - step : '0);

  // ======================================================================
  // State register
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_out <= '0;
    end else if (load_in) begin
      state_out <= load_value_in;
    end else if (tick_in && !freeze_in) begin
      state_out <= next_state;
    end
  end

endmodule : mtp_thermal_acc

//--- tb_top.sv
/*
  Self-checking bench of the motor thermal protection block.
  Assumes the thermal and phase counts are shortened by parameters.
*/
`timescale 1ns/10ps

module tb_top;
  localparam int TICK = 8;
  localparam int PH = 5;
  logic mclk_in, rst_in, rd, wr, waitreq, run, power, overload, contactor;
  logic [4:0] address;
  logic [31:0] wdata, rdata, got, therm_a;
  logic [11:0] ptc_set, ohms;
  logic [15:0] isq;
  logic [2:0] lines;
  logic [39:0] ret_in, ret_out, saved;
  logic ret_wr, stop, relay, irq;
  int n_errors, n_compared, n, k, saves0;
  int n_saves = 0;
  // Cycles for 0.5 percent of heating; a tick period outlasts the save path
  int trip_cyc[3] = '{1032, 2032, 3056};

  mtp_protect #(.TICK_CYC(TICK), .PHASE_MS(PH)) u_dut (.mclk_in(mclk_in), .rst_in(rst_in),
    .avs_address_in(address), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .current_sq_in(isq), .ptc_ohms_in(ohms), .run_cmd_in(run), .line_ok_in(lines),
    .power_ok_in(power), .retained_data_in(ret_in), .retained_data_out(ret_out),
    .retained_write_out(ret_wr), .motor_stop_out(stop), .thermal_relay_out(relay),
    .irq_out(irq));

  mtp_motor_model u_motor (.mclk_in(mclk_in), .run_in(run), .stop_in(stop),
    .overload_in(overload), .contactor_in(contactor), .ohms_set_in(ptc_set),
    .current_sq_out(isq), .ptc_ohms_out(ohms), .line_ok_out(lines));

  // ======================================================================
  // Clock and save capture
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end

  always @(posedge mclk_in) begin
    if (ret_wr === 1'b1) begin
      saved <= ret_out;
      n_saves <= n_saves + 1;
    end
  end

  // ======================================================================
  // Tasks
  task tally_and_finish;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  task check32(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check32

  task check_in(input int g, input int lo, input int hi);
    n_compared++;
    if (g < lo || g > hi) begin
      n_errors++;
      $display("unexpected count at %0t: got %h expected %h..%h", $time, g, lo, hi);
    end
  endtask : check_in

  task settle(input int c);
    repeat (c) @(posedge mclk_in);
  endtask : settle

  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge mclk_in);
    address <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge mclk_in);
      t++;
    end while (waitreq !== 1'b0 && t < 50);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (t >= 50) begin
      n_errors++;
      $display("unexpected stall at %0t: got %h expected %h", $time, waitreq, 1'b0);
    end
  endtask : bus

  task rd_chk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    check32(got, e);
  endtask : rd_chk

  task do_reset(input logic [39:0] saved_state);
    @(posedge mclk_in);
    rst_in <= 1'b1;
    run <= 1'b0;
    power <= 1'b0;
    overload <= 1'b0;
    ret_in <= saved_state;
    settle(2);
    rst_in <= 1'b0;
    settle(2);
  endtask : do_reset

  // ======================================================================
  // Watchdog
  initial begin
    repeat (60000) @(posedge mclk_in);
    n_errors++;
    $display("unexpected timeout at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    tally_and_finish();
  end

  // ======================================================================
  // Tests
  initial begin
    {rd, wr, run, power, overload, contactor} = 6'h00;
    address = 5'h00;
    wdata = 32'h00000000;
    ptc_set = 12'h2EE;
    ret_in = 40'h0000000000;
    n_errors = 0;
    n_compared = 0;
    rst_in = 1'b1;
    settle(6);
    rst_in <= 1'b0;
    rd_chk(5'h00, 32'h00000010);
    rd_chk(5'h14, 32'h00000B54);
    rd_chk(5'h1C, 32'h00000000);
    rd_chk(5'h04, 32'h00000000);
    // Probe threshold clamps, trip edge, interrupt mask and clear
    bus(1'b1, 5'h14, 32'h000003E8);
    rd_chk(5'h14, 32'h00000A8C);
    bus(1'b1, 5'h14, 32'h00000FA0);
    rd_chk(5'h14, 32'h00000C1C);
    bus(1'b1, 5'h14, 32'h00000B54);
    bus(1'b1, 5'h00, 32'h00000018);
    ptc_set <= 12'hB53;
    settle(4);
    rd_chk(5'h04, 32'h00000000);
    ptc_set <= 12'hB54;
    settle(4);
    rd_chk(5'h04, 32'h00000004);
    check32({31'h0, irq}, 32'h00000000);
    check32({31'h0, stop}, 32'h00000001);
    bus(1'b1, 5'h10, 32'h00000004);
    settle(2);
    check32({31'h0, irq}, 32'h00000001);
    bus(1'b1, 5'h0C, 32'h00000004);
    settle(2);
    check32({31'h0, irq}, 32'h00000000);
    ptc_set <= 12'h2EE;
    // Line presence after the run command, contactor open then closed
    for (k = 0; k < 2; k++) begin
      do_reset(40'h0000000000);
      contactor <= k[0];
      power <= 1'b1;
      settle(4);
      run <= 1'b1;
      settle((PH - 1) * TICK);
      rd_chk(5'h04, 32'h00000010);
      settle(12);
      rd_chk(5'h04, k ? 32'h00000010 : 32'h00000018);
    end
    // Class trip times from a restored 124.5 percent state
    for (k = 0; k < 3; k++) begin
      do_reset(40'h07C8000000);
      saves0 = n_saves;
      contactor <= 1'b1;
      bus(1'b1, 5'h00, 32'h00000018 | k);
      power <= 1'b1;
      settle(6);
      bus(1'b0, 5'h08, 32'h00000000);
      check32({24'h0, got[31:24]}, 32'h0000007C);
      rd_chk(5'h04, 32'h00000001);
      run <= 1'b1;
      settle(6);
      overload <= 1'b1;
      n = 0;
      while (stop !== 1'b1 && n < 4000) begin
        @(negedge mclk_in);
        n++;
      end
      check_in(n, trip_cyc[k] * 95 / 100, trip_cyc[k] * 105 / 100 + 8);
      check32({31'h0, relay}, 32'h00000001);
      rd_chk(5'h04, 32'h00000013);
      run <= 1'b0;
      settle(6);
      check32({20'h0, saved[39:28]}, 32'h0000007D);
      power <= 1'b0;
      settle(6);
      bus(1'b0, 5'h08, 32'h00000000);
      therm_a = got;
      settle(200);
      rd_chk(5'h08, therm_a);
      check_in(n_saves - saves0, 2, 2);
    end
    tally_and_finish();
  end
endmodule : tb_top
